// ---- coproc_mul_div_unit.sv ----
/*
 Coprocessor multiplier/divider: sixteen byte registers reached by the
 cpu's coprocessor transfers in byte, word, double or quad groups.
 Assumes the cpu drives cpReq from logic on sys_clk and waits the
 operation time before reading results or stopping its clock.
*/
`include "cp_mul_div_defs.svh"

// How it works
// - writing byte 7 starts the operation
// - mul/mac 4, div32/16 8, div32/32 16 cycles
// - select codes 0,1,2,3,5 valid; others idle
// - mode bit 4: 0 unsigned, 1 signed
// - enable bit 7; clearing lets current finish
// - status bit 8 shows operation running
// - carry on carry-out or zero divisor
// - zero flag when result is zero
// - negative flag; mac uses result msb
// - overflow when two's complement range exceeded; unsigned mac on carry-out
// - cpu may write the five result flags
// - saturation flag sticky until software clears
// - unaffected flags keep value; only saturating sets q
// - unused result bytes keep old contents
// - mode byte combines enable, sign, select
// - identification byte fixed, byte 14 zero
// - byte, word, double, quad group access
// - saturate to 7FFF_FFFF or 8000_0000 signed, all ones unsigned
// - signed mode: msb is sign
module coproc_mul_div_unit
   import cp_mul_div_pkg::*;
#(
   parameter logic [7:0] ID_CODE   = 8'h5A, // arbitrary value
   parameter int         CYC_MUL   = `CYC_MUL,
   parameter int         CYC_DIV16 = `CYC_DIV16,
   parameter int         CYC_DIV32 = `CYC_DIV32
)(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   input  wire cp_req_t     cpReq,
   output logic [63:0]      cpRdata,
   output logic             opBusy
);

   if (CYC_MUL < 1 || CYC_MUL > 16 || CYC_DIV16 < 1 || CYC_DIV16 > 16 ||
       CYC_DIV32 < 1 || CYC_DIV32 > 16) begin : g_bad_cycles
      $error("operation cycle counts must lie in 1..16");
   end

   ////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [3:0] grpMask(input logic [1:0] sz);
      grpMask = 4'(4'hF << sz);
   endfunction

   function automatic logic [16:0] ext17(input logic [15:0] v,
                                         input logic sgn);
      ext17 = {sgn & v[15], v};
   endfunction

   function automatic logic [3:0] opCycles(input logic [2:0] op);
      case (op)
         OP_DIV16: opCycles = 4'(CYC_DIV16 - 1);
         OP_DIV32: opCycles = 4'(CYC_DIV32 - 1);
         default:  opCycles = 4'(CYC_MUL - 1);
      endcase
   endfunction

   function automatic logic opValid(input logic [2:0] op);
      opValid = (op == OP_MUL) || (op == OP_DIV16) || (op == OP_MACN) ||
                (op == OP_MACS) || (op == OP_DIV32);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state

   logic [7:0]  opReg [8];
   logic [7:0]  opNext [8];
   logic [7:0]  modeReg, modeNext;
   flags_t      flagReg, flagNext;
   run_state_t  stateReg, stateNext;
   logic [3:0]  cntReg, cntNext;
   logic [2:0]  runOpReg, runOpNext;
   logic        runSignReg, runSignNext;
   logic [63:0] rdReg, rdNext;

   logic [7:0]  view [16];
   logic [3:0]  base, idx, mask;
   logic [2:0]  lane;
   logic [7:0]  wb;
   logic        startHit;

   // arithmetic results
   logic [15:0] mcand, mplier;
   logic [31:0] addend, hi32, divisor, resLo, resHi;
   logic [33:0] prod;
   logic [32:0] macU, macS, nd, dd, quo, rem;
   logic        sgn, divZero;
   logic [3:0]  hiMask;
   flags_t      hwFlags, upd;

   assign opBusy  = (stateReg == ST_RUN);
   assign cpRdata = rdReg;

   ////////////////////////////////////////////////////////////////////
   // arithmetic on the held operands, used on the last run cycle

   always_comb begin
      sgn     = runSignReg;
      mcand   = {opReg[7], opReg[6]};
      mplier  = {opReg[5], opReg[4]};
      addend  = {opReg[3], opReg[2], opReg[1], opReg[0]};
      hi32    = {opReg[7], opReg[6], opReg[5], opReg[4]};
      prod    = 34'($signed(ext17(mcand, sgn)) *
                    $signed(ext17(mplier, sgn)));
      macU    = {1'b0, prod[31:0]} + {1'b0, addend};
      macS    = {prod[31], prod[31:0]} + {addend[31], addend};
      divisor = (runOpReg == OP_DIV16) ?
                {{16{sgn & opReg[7][7]}}, mcand} : hi32;
      divZero = (divisor == 32'h0);
      nd      = {sgn & addend[31], addend};
      // a dummy divisor keeps the divider defined; result is replaced
      dd      = divZero ? 33'h1 : {sgn & divisor[31], divisor};
      quo     = 33'($signed(nd) / $signed(dd));
      rem     = 33'($signed(nd) % $signed(dd));
      resLo   = addend;
      resHi   = hi32;
      hiMask  = 4'h0;
      hwFlags = '0;
      upd     = '0;
      unique case (runOpReg)
         OP_MUL: begin
            resLo = prod[31:0];
            upd.z = 1'b1;
            upd.s = sgn;
         end
         OP_DIV16, OP_DIV32: begin
            resLo      = divZero ? `SAT_UMAX : quo[31:0];
            resHi      = divZero ? addend : rem[31:0];
            hiMask     = (runOpReg == OP_DIV16) ? 4'h3 : 4'hF;
            hwFlags.c  = divZero;
            hwFlags.ov = sgn & ~divZero & (quo[32] != quo[31]);
            upd.c      = 1'b1;
            upd.z      = 1'b1;
            upd.s      = sgn;
            upd.ov     = sgn;
         end
         OP_MACN, OP_MACS: begin
            resLo      = sgn ? macS[31:0] : macU[31:0];
            hwFlags.c  = macU[32];
            hwFlags.ov = sgn ? (macS[32] != macS[31]) : macU[32];
            upd.c      = 1'b1;
            upd.z      = 1'b1;
            upd.s      = 1'b1;
            upd.ov     = 1'b1;
            if (runOpReg == OP_MACS) begin
               upd.q     = 1'b1;
               hwFlags.q = hwFlags.ov;
               if (hwFlags.ov) begin
                  resLo = sgn ? (macS[32] ? `SAT_NEG : `SAT_POS)
                              : `SAT_UMAX;
               end
            end
         end
         default: begin
            resLo = addend;
         end
      endcase
      hwFlags.z = (resLo == 32'h0);
      hwFlags.s = resLo[31];
   end

   ////////////////////////////////////////////////////////////////////
   // register view for reads

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         view[i] = `BYTE_RST;
      end
      for (int i = 0; i < 8; i++) begin
         view[i] = opReg[i];
      end
      view[`REG_MODE] = modeReg;
      view[`REG_STATUS][`ST_C_BIT]   = flagReg.c;
      view[`REG_STATUS][`ST_Z_BIT]   = flagReg.z;
      view[`REG_STATUS][`ST_S_BIT]   = flagReg.s;
      view[`REG_STATUS][`ST_OV_BIT]  = flagReg.ov;
      view[`REG_STATUS][`ST_Q_BIT]   = flagReg.q;
      view[`REG_STATUS][`ST_USE_BIT] = opBusy;
      view[`REG_ID] = ID_CODE;
   end

   ////////////////////////////////////////////////////////////////////
   // next state: cpu writes, start, run, completion, reads

   always_comb begin
      opNext      = opReg;
      modeNext    = modeReg;
      flagNext    = flagReg;
      stateNext   = stateReg;
      cntNext     = cntReg;
      runOpNext   = runOpReg;
      runSignNext = runSignReg;
      rdNext      = rdReg;
      mask        = grpMask(cpReq.size);
      base        = cpReq.addr & mask;
      startHit    = 1'b0;
      idx         = 4'h0;
      lane        = 3'h0;
      wb          = 8'h0;
      for (int i = 0; i < 16; i++) begin
         idx  = 4'(i);
         lane = 3'(idx & ~mask);
         wb   = cpReq.wdata[8 * lane +: 8];
         if (cpReq.wr && ((idx & mask) == base)) begin
            if (i < 8) begin
               opNext[i] = wb;
            end else if (idx == `REG_MODE) begin
               modeNext = wb & `MODE_WMASK;
            end else if (idx == `REG_STATUS) begin
               flagNext.c  = wb[`ST_C_BIT];
               flagNext.z  = wb[`ST_Z_BIT];
               flagNext.s  = wb[`ST_S_BIT];
               flagNext.ov = wb[`ST_OV_BIT];
               flagNext.q  = wb[`ST_Q_BIT];
            end
            if (idx == `OPB_TOP) begin
               startHit = 1'b1;
            end
         end
      end
      unique case (stateReg)
         ST_IDLE: begin
            // enable and mode as they stood before this write
            if (startHit && modeReg[`MODE_EN_BIT] &&
                opValid(modeReg[2:0])) begin
               stateNext   = ST_RUN;
               cntNext     = opCycles(modeReg[2:0]);
               runOpNext   = modeReg[2:0];
               runSignNext = modeReg[`MODE_SIGN_BIT];
            end
         end
         ST_RUN: begin
            // mode was latched at start, so clearing enable lets it end
            if (cntReg == 4'h0) begin
               stateNext = ST_IDLE;
               for (int i = 0; i < 4; i++) begin
                  opNext[i] = resLo[8 * i +: 8];
                  if (hiMask[i]) begin
                     opNext[i + 4] = resHi[8 * i +: 8];
                  end
               end
               // hardware update wins over a same-cycle cpu write
               if (upd.c) flagNext.c = hwFlags.c;
               if (upd.z) flagNext.z = hwFlags.z;
               if (upd.s) flagNext.s = hwFlags.s;
               if (upd.ov) flagNext.ov = hwFlags.ov;
               if (upd.q && hwFlags.q) flagNext.q = 1'b1;
            end else begin
               cntNext = cntReg - 4'h1;
            end
         end
         default: begin
            stateNext = ST_IDLE;
         end
      endcase
      if (cpReq.rd) begin
         for (int k = 0; k < 8; k++) begin
            rdNext[8 * k +: 8] = (k < (1 << cpReq.size)) ?
                                 view[4'(base + 4'(k))] : 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            opReg[i] <= `BYTE_RST;
         end
         modeReg    <= `MODE_RST;
         flagReg    <= '0;
         stateReg   <= ST_IDLE;
         cntReg     <= 4'h0;
         runOpReg   <= 3'h0;
         runSignReg <= 1'b0;
         rdReg      <= 64'h0;
      end else if (clkEn) begin
         opReg      <= opNext;
         modeReg    <= modeNext;
         flagReg    <= flagNext;
         stateReg   <= stateNext;
         cntReg     <= cntNext;
         runOpReg   <= runOpNext;
         runSignReg <= runSignNext;
         rdReg      <= rdNext;
      end
   end

endmodule

// ---- coproc_mul_div_unit_properties.sv ----
/*
 Port checker for the coprocessor multiplier/divider.
 Assumes it is bound to coproc_mul_div_unit and sees its ports only.
*/
module coproc_mul_div_unit_checker
   import cp_mul_div_pkg::*;
#(
   parameter logic [7:0] ID_CODE   = 8'h5A, // arbitrary value
   parameter int         CYC_MUL   = 4,
   parameter int         CYC_DIV16 = 8,
   parameter int         CYC_DIV32 = 16
)(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        clkEn,
   input wire cp_req_t     cpReq,
   input wire logic [63:0] cpRdata,
   input wire logic        opBusy
);
   logic [7:0] mode_reg, mode_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [2:0] sel_reg, sel_next;
   logic [3:0] base;
   logic       wr7;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   function automatic logic hit(input logic [3:0] b, input logic [1:0] s,
                                input int k);
      return k >= int'(b) && k < int'(b) + (1 << s);
   endfunction
   function automatic int lenOf(input logic [2:0] s);
      return s == OP_DIV16 ? CYC_DIV16 : s == OP_DIV32 ? CYC_DIV32 : CYC_MUL;
   endfunction
   function automatic logic rdB(input cp_req_t r, input logic e, int k);
      return e && r.rd && r.size == 2'h0 && int'(r.addr) == k;
   endfunction
   assign base = cpReq.addr & ~((4'h1 << cpReq.size) - 4'h1);
   assign wr7  = clkEn && cpReq.wr && hit(base, cpReq.size, 7);
   // start decision uses the mode held before the same-edge write
   always_comb begin
      mode_next = mode_reg;
      sel_next  = sel_reg;
      cnt_next  = cnt_reg;
      if (clkEn && cpReq.wr && hit(base, cpReq.size, 8)) begin
         mode_next = cpReq.wdata[8*(8-int'(base)) +: 8] & 8'h97;
      end
      if (!opBusy) begin
         cnt_next = 5'h00;
         sel_next = mode_reg[2:0];
      end else if (clkEn) begin
         cnt_next = cnt_reg + 5'h01;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= 8'h00;
         sel_reg  <= 3'h0;
         cnt_reg  <= 5'h00;
      end else begin
         mode_reg <= mode_next;
         sel_reg  <= sel_next;
         cnt_reg  <= cnt_next;
      end
   end
   sequence s_idleTrig;
      wr7 && !opBusy;
   endsequence
   sequence s_goodTrig;
      s_idleTrig ##0 mode_reg[7] && mode_reg[2:0] inside {0, 1, 2, 3, 5};
   endsequence
   a_start_busy: assert property (s_goodTrig |=> opBusy)
      else $error("top byte write did not start");
   a_off_idle: assert property (s_idleTrig ##0 !mode_reg[7] |=> !opBusy)
      else $error("disabled unit started");
   a_nosel_idle: assert property (
      s_idleTrig ##0 mode_reg[2:0] inside {4, 6, 7} |=> !opBusy)
      else $error("no-operation code started");
   a_op_length: assert property (
      $fell(opBusy) |-> cnt_reg == 5'(lenOf(sel_reg)))
      else $error("operation time wrong");
   a_busy_read: assert property (rdB(cpReq, clkEn, 9) |=>
      cpRdata[63:8] == 56'h0 && cpRdata[2:0] == {2'b00, $past(opBusy)})
      else $error("status in-progress bit wrong");
   a_mode_read: assert property (rdB(cpReq, clkEn, 8) |=>
      cpRdata == {56'h0, $past(mode_reg)})
      else $error("mode byte readback wrong");
   a_id_read: assert property (rdB(cpReq, clkEn, 15) |=>
      cpRdata == {56'h0, ID_CODE})
      else $error("identification byte wrong");
   a_pad_zero: assert property (clkEn && cpReq.rd && cpReq.size == 2'h0 &&
      cpReq.addr inside {[10:14]} |=> cpRdata == 64'h0)
      else $error("unused byte not zero");
endmodule

bind coproc_mul_div_unit coproc_mul_div_unit_checker #(.ID_CODE(ID_CODE),
   .CYC_MUL(CYC_MUL), .CYC_DIV16(CYC_DIV16), .CYC_DIV32(CYC_DIV32))
   chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
   .cpReq(cpReq), .cpRdata(cpRdata), .opBusy(opBusy));

// ---- cp_mul_div_defs.svh ----
/*
 Register indices, bit positions, reset values and operation timing of
 the coprocessor multiplier/divider. Assumes the includer uses the
 names only; no logic here.
*/
`ifndef CP_MUL_DIV_DEFS_SVH
`define CP_MUL_DIV_DEFS_SVH

// byte register indices
`define OPB_TOP      4'h7
`define REG_MODE     4'h8
`define REG_STATUS   4'h9
`define REG_ID       4'hF

// operation_config bits
`define MODE_EN_BIT   7
`define MODE_SIGN_BIT 4
`define MODE_WMASK    8'h97

// operation_result_flags bits within byte 9 (word bits 15..8)
`define ST_C_BIT     7
`define ST_Z_BIT     6
`define ST_S_BIT     5
`define ST_OV_BIT    4
`define ST_Q_BIT     3
`define ST_USE_BIT   0

`define BYTE_RST     8'h00
`define MODE_RST     8'h00

// operation time in cpu clock cycles
`define CYC_MUL      4
`define CYC_DIV16    8
`define CYC_DIV32    16

`define SAT_POS      32'h7FFF_FFFF
`define SAT_NEG      32'h8000_0000
`define SAT_UMAX     32'hFFFF_FFFF

`endif

// ---- cp_mul_div_pkg.sv ----
/*
 Types shared by the coprocessor multiplier/divider: operation codes,
 control states, flag set and the coprocessor transfer request.
 Assumes cp_mul_div_defs.svh for numeric constants.
*/
package cp_mul_div_pkg;

   typedef enum logic [2:0] {
      OP_MUL   = 3'h0,
      OP_DIV16 = 3'h1,
      OP_MACN  = 3'h2,
      OP_MACS  = 3'h3,
      OP_DIV32 = 3'h5
   } op_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } run_state_t;

   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic ov;
      logic q;
   } flags_t;

   // size: 0 byte, 1 word, 2 double word, 3 quad word
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [1:0]  size;
      logic [63:0] wdata;
   } cp_req_t;

endpackage

// ---- cpu_xfer_model.sv ----
/*
 Behavioural cpu issuing coprocessor transfers.
 Assumes callers step it from one process; requests change after edges.
*/
module cpu_xfer_model
   import cp_mul_div_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic [63:0] cpRdata,
   output cp_req_t          cpReq
);
   timeunit 1ns;
   timeprecision 1ns;
   initial cpReq = '0;
   task automatic put(input logic w, input logic [3:0] a,
                      input logic [1:0] s, input logic [63:0] d);
      @(posedge sys_clk);
      cpReq <= '{wr: w, rd: !w, addr: a, size: s, wdata: d};
      @(posedge sys_clk);
      cpReq.wr <= 1'b0;
      cpReq.rd <= 1'b0;
      cpReq.wdata <= ~d;  // released data never repeats the last value
   endtask
   task automatic get(input logic [3:0] a, input logic [1:0] s,
                      output logic [63:0] q);
      put(1'b0, a, s, 64'h0);
      #1 q = cpRdata;
   endtask
   task automatic run(input logic [15:0] cfg, input logic [1:0] s,
                      input logic [63:0] ops, input int n,
                      output logic [63:0] q);
      put(1'b1, 4'h8, s, {48'h0, cfg});
      put(1'b1, 4'h0, 2'h3, ops);
      repeat (n) @(posedge sys_clk);
      get(4'h0, 2'h3, q);
   endtask
endmodule

// ---- test_coproc_mul_div_unit.sv ----
/*
 Self-checking bench for the coprocessor multiplier/divider.
 Assumes the bound checker and cpu_xfer_model are compiled first.
*/
module test_coproc_mul_div_unit
   import cp_mul_div_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ID = 8'h3C;  // arbitrary value
   typedef struct packed {
      logic [7:0]  cfg;
      logic [4:0]  n;
      logic [63:0] ops;
      logic [63:0] res;
      logic [7:0]  st;
   } row_t;
   localparam row_t ROWS [14] = '{
      '{8'h80, 4, 64'hAA55_1234_1111_1111, 64'hAA55_1234_0C1C_9344, 8'h00},
      '{8'h90, 4, 64'hAA55_1234_1111_1111, 64'hAA55_1234_F9E8_9344, 8'h20},
      '{8'h81, 8, 64'h0010_7777_0000_1234, 64'h0010_0004_0000_0123, 8'h00},
      '{8'h81, 8, 64'h0000_9999_0000_5678, 64'h0000_5678_FFFF_FFFF, 8'h80},
      '{8'h95, 16, 64'hFFFF_FFFD_FFFF_FFF9, 64'hFFFF_FFFF_0000_0002, 8'h00},
      '{8'h82, 4, 64'hFFFF_FFFF_0001_FFFF, 64'hFFFF_FFFF_0000_0000, 8'hD0},
      '{8'h93, 4, 64'h7FFF_7FFF_7FFF_FFFF, 64'h7FFF_7FFF_7FFF_FFFF, 8'h18},
      '{8'h93, 4, 64'h8000_7FFF_8000_0000, 64'h8000_7FFF_8000_0000, 8'hB8},
      '{8'h83, 4, 64'hFFFF_FFFF_0001_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 8'hB8},
      '{8'h84, 0, 64'h0001_0002_0000_0003, 64'h0001_0002_0000_0003, 8'h00},
      '{8'h86, 0, 64'h0001_0002_0000_0003, 64'h0001_0002_0000_0003, 8'h00},
      '{8'h87, 0, 64'h0001_0002_0000_0003, 64'h0001_0002_0000_0003, 8'h00},
      '{8'h91, 8, 64'hFFFE_0000_0000_0007, 64'hFFFE_0001_FFFF_FFFD, 8'h20},
      '{8'h92, 4, 64'h7FFF_7FFF_7FFF_FFFF, 64'h7FFF_7FFF_BFFF_0000, 8'h30}};
   logic        sys_clk, rst_n, clkEn, opBusy;
   cp_req_t     cpReq;
   logic [63:0] cpRdata, q;
   int          badCount, totalChecks;
   coproc_mul_div_unit #(.ID_CODE(ID), .CYC_MUL(4), .CYC_DIV16(8),
      .CYC_DIV32(16)) coproc_mul_div_unit_i (.sys_clk(sys_clk),
      .rst_n(rst_n), .clkEn(clkEn), .cpReq(cpReq), .cpRdata(cpRdata),
      .opBusy(opBusy));
   cpu_xfer_model cpu_xfer_model_i (.sys_clk(sys_clk), .cpRdata(cpRdata),
      .cpReq(cpReq));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finalReport();
      if (badCount == 0 && totalChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // whole run is near 270 cycles; over eighteen times that means a hang
   initial begin
      repeat (5000) @(posedge sys_clk);
      badCount++;
      finalReport();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      badCount = 0;
      totalChecks = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (ROWS[i]) begin
         cpu_xfer_model_i.run({8'h00, ROWS[i].cfg}, 2'h1, ROWS[i].ops,
                              ROWS[i].n, q);
         chk(q, ROWS[i].res);
         cpu_xfer_model_i.get(4'h9, 2'h0, q);
         chk(q, {56'h0, ROWS[i].st});
      end
      // q stays set through a multiply that keeps the status byte
      cpu_xfer_model_i.run(16'h0093, 2'h1, ROWS[6].ops, 4, q);
      cpu_xfer_model_i.run(16'h0080, 2'h0, 64'h0002_0003_0000_0000, 4, q);
      chk(q, 64'h0002_0003_0000_0006);
      cpu_xfer_model_i.get(4'h9, 2'h0, q);
      chk(q, 64'h18);
      cpu_xfer_model_i.put(1'b1, 4'h9, 2'h0, 64'h00);
      cpu_xfer_model_i.get(4'h9, 2'h0, q);
      chk(q, 64'h0);
      // enable dropped mid-run, plus a clock-enable stall
      cpu_xfer_model_i.put(1'b1, 4'h8, 2'h0, 64'h85);
      cpu_xfer_model_i.put(1'b1, 4'h0, 2'h3, 64'h0000_0007_0000_0064);
      cpu_xfer_model_i.put(1'b1, 4'h8, 2'h0, 64'h05);
      @(posedge sys_clk) clkEn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      clkEn <= 1'b1;
      cpu_xfer_model_i.get(4'h9, 2'h0, q);
      chk(q, 64'h01);
      chk({63'h0, opBusy}, 64'h1);
      repeat (20) @(posedge sys_clk);
      cpu_xfer_model_i.get(4'h0, 2'h3, q);
      chk(q, 64'h0000_0002_0000_000E);
      cpu_xfer_model_i.put(1'b1, 4'h7, 2'h0, 64'h00);
      @(posedge sys_clk) #1 chk({63'h0, opBusy}, 64'h0);
      // all-ones over mode..id: only writable bits stick
      cpu_xfer_model_i.put(1'b1, 4'h8, 2'h3, 64'hFFFF_FFFF_FFFF_FFFF);
      cpu_xfer_model_i.get(4'h8, 2'h3, q);
      chk(q, {ID, 40'h0, 8'hF8, 8'h97});
      cpu_xfer_model_i.get(4'hC, 2'h0, q);
      chk(q, 64'h0);
      cpu_xfer_model_i.get(4'h8, 2'h0, q);
      chk(q, 64'h97);
      cpu_xfer_model_i.get(4'hF, 2'h0, q);
      chk(q, {56'h0, ID});
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      cpu_xfer_model_i.get(4'h8, 2'h3, q);
      chk(q, {ID, 56'h0});
      cpu_xfer_model_i.get(4'hE, 2'h1, q);
      chk(q, {48'h0, ID, 8'h00});
      finalReport();
   end
endmodule
